// file: phy_test_ptp_fef_config.sv
// Summary of operation
// [R1] compliance bit 4 enables the selected 10BASE-Te test pattern
// [R2] compliance low nibble picks the 10BASE-Te pattern, codes up to 1100
// [R3] extended register bit 4 enables the 100BASE-TX test modes
// [R4] five-bit value gives zeros after each one in 100BASE-TX test
// [R5] software toggles the extended enable to load a new pattern
// [R6] software forces link speed before running any test mode
// [R7] pin select bits 6:4 route the transmit start-of-frame pulse
// [R8] pin select bits 2:0 route the receive pulse, same encoding
// [R9] timing bits 15:13 delay the transmit indication in 8 ns steps
// [R10] timing bits 12:10 delay the receive indication in 8 ns steps
// [R11] timing bits 9:8 choose the transmit error input pin
// [R12] timing bits 7:4 hold the descrambler unlock link-down timer
// [R13] fault register bit 13 forces the link up at 100 Mbps
// [R14] fault register bit 6 stops far-end fault generation
// [R15] fault register bit 5 ignores received far-end faults
// [R16] an assigned pin serves its assigned function, not its normal one
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "phy_cfg_defs.svh"
module phy_test_ptp_fef_config
  import phy_cfg_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // start-of-frame pulses from the core
  input  wire logic        tx_sfd_pulse,
  input  wire logic        rx_sfd_pulse,
  // normal pin functions from the core
  input  wire logic        led_zero_func,
  input  wire logic        crs_func,
  input  wire logic        col_func_out,
  input  wire logic        col_func_oe,
  input  wire logic        int_func_out,
  input  wire logic        int_func_oe,
  // pins
  output logic             led_zero_pin,
  output logic             crs_pin,
  input  wire logic        col_in,
  output logic             col_out,
  output logic             col_oe,
  input  wire logic        interrupt_powerdown_in,
  output logic             interrupt_powerdown_out,
  output logic             interrupt_powerdown_oe,
  // transmit error toward the core
  output logic             tx_error,
  // test pattern control
  output logic             te_test_active,
  output logic      [3:0]  te_test_select,
  output logic             te_test_bit,
  output logic             tx100_test_active,
  output logic      [4:0]  tx100_zero_count,
  output logic             tx100_shift_clear,
  output logic             tx100_test_bit,
  // link and far-end fault
  output logic      [3:0]  descr_unlock_timer,
  output logic             force_100_link,
  input  wire logic        far_end_fault_req,
  output logic             far_end_fault_gen,
  input  wire logic        far_end_fault_rx,
  output logic             far_end_fault_detected
);

  logic [15:0] compliance_test_control_reg;
  logic [15:0] timestamp_pin_select_reg;
  logic [15:0] timestamp_timing_config_reg;
  logic [15:0] fiber_far_end_fault_force_reg;
  logic [15:0] tx100_ext_reg;
  logic [15:0] rdata_next;
  logic        tx100_en_q_reg;
  logic [4:0]  tx100_latched_reg;
  logic        te_prev_en_reg;
  logic        te_sent_reg;
  logic [1:0]  te_phase_reg;
  logic [14:0] te_lfsr_reg;
  logic        tx_sfd_dly;
  logic        rx_sfd_dly;
  logic [2:0]  tx_dly_cycles;
  logic [2:0]  rx_dly_cycles;
  pin_sel_t    tx_pin;
  pin_sel_t    rx_pin;
  txer_sel_t   txer_pin;
  logic        tx100_en;
  logic        te_en;
  logic [3:0]  te_sel;

  // step count to clock cycles, rounded up
  function automatic logic [2:0] ts_cycles(input logic [2:0] steps);
    int ns;
    ns = int'(steps) * `TS_STEP_NS;
    return 3'((ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      compliance_test_control_reg <= `RST_COMPLIANCE;
    else if (reg_wr && reg_addr == `ADDR_COMPLIANCE)
      compliance_test_control_reg <= reg_wdata;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      tx100_ext_reg <= `RST_TX100_EXT;
    else if (reg_wr && reg_addr == `ADDR_TX100_EXT)
      tx100_ext_reg <= reg_wdata & `MASK_TX100_EXT;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      timestamp_pin_select_reg <= `RST_PIN_SEL;
    else if (reg_wr && reg_addr == `ADDR_PIN_SEL)
      timestamp_pin_select_reg <= reg_wdata & `MASK_PIN_SEL;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      timestamp_timing_config_reg <= `RST_TIMING;
    else if (reg_wr && reg_addr == `ADDR_TIMING)
      timestamp_timing_config_reg <= reg_wdata;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      fiber_far_end_fault_force_reg <= `RST_FAULT;
    else if (reg_wr && reg_addr == `ADDR_FAULT)
      fiber_far_end_fault_force_reg <= reg_wdata;
  end

  always_comb
  begin
    case (reg_addr)
      `ADDR_COMPLIANCE: rdata_next = compliance_test_control_reg;
      `ADDR_PIN_SEL:    rdata_next = timestamp_pin_select_reg;
      `ADDR_TIMING:     rdata_next = timestamp_timing_config_reg;
      `ADDR_FAULT:      rdata_next = fiber_far_end_fault_force_reg;
      `ADDR_TX100_EXT:  rdata_next = tx100_ext_reg;
      default:          rdata_next = 16'h0000;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= 16'h0000;
  end

  // [R1] 10BASE-Te enable
  assign te_en  = compliance_test_control_reg[`CT_TE_EN_BIT];
  assign te_sel = compliance_test_control_reg[`CT_SEL_MSB:`CT_SEL_LSB];

  // [R2] codes past the last idle variant give no pattern
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      te_test_active <= 1'b0;
      te_test_select <= 4'h0;
    end
    else
    begin
      te_test_active <= te_en && te_sel <= `TE_SEL_MAX;
      te_test_select <= te_sel;
    end
  end

  // [R2] pattern bits; link pulses and idle shapes are left to the line driver
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      te_prev_en_reg <= 1'b0;
      te_sent_reg    <= 1'b0;
      te_phase_reg   <= 2'h0;
      te_lfsr_reg    <= 15'h7FFF;
      te_test_bit    <= 1'b0;
    end
    else
    begin
      te_prev_en_reg <= te_test_active;
      te_phase_reg   <= te_phase_reg + 2'h1;
      te_lfsr_reg    <= {te_lfsr_reg[13:0], te_lfsr_reg[14] ^ te_lfsr_reg[13]};
      if (!te_test_active || !te_prev_en_reg)
        te_sent_reg <= 1'b0;
      else
        te_sent_reg <= 1'b1;
      if (!te_test_active)
        te_test_bit <= 1'b0;
      else
      begin
        case (te_sel)
          4'h1, 4'h6: te_test_bit <= !te_sent_reg;
          4'h3:       te_test_bit <= 1'b1;
          4'h5:       te_test_bit <= ~te_phase_reg[0];
          4'h8:       te_test_bit <= te_phase_reg == 2'h0 || te_phase_reg == 2'h3;
          4'h9:       te_test_bit <= te_lfsr_reg[14];
          default:    te_test_bit <= 1'b0;
        endcase
      end
    end
  end

  // [R3] 100BASE-TX test enable
  assign tx100_en = tx100_ext_reg[`EXT_EN_BIT];

  // [R5] pattern is loaded only on the enable's rising edge
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      tx100_en_q_reg    <= 1'b0;
      tx100_latched_reg <= 5'h00;
    end
    else
    begin
      tx100_en_q_reg <= tx100_en;
      if (tx100_en && !tx100_en_q_reg)
        tx100_latched_reg <= {tx100_ext_reg[`EXT_MSB_BIT], te_sel};
    end
  end

  // [R4] zero run length and shift register clear
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      tx100_test_active <= 1'b0;
      tx100_zero_count  <= 5'h00;
      tx100_shift_clear <= 1'b0;
    end
    else
    begin
      tx100_test_active <= tx100_en && tx100_en_q_reg;
      tx100_zero_count  <= tx100_latched_reg;
      tx100_shift_clear <= tx100_en && tx100_en_q_reg && tx100_latched_reg == 5'h00;
    end
  end

  // [R4] one followed by the programmed zeros
  tx_test_pattern_gen u_tx_gen
  (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .enable     (tx100_test_active),
    .zero_count (tx100_zero_count),
    .bit_out    (tx100_test_bit)
  );

  // [R9] transmit indication offset
  assign tx_dly_cycles = ts_cycles(timestamp_timing_config_reg[`TC_TX_MSB:`TC_TX_LSB]);
  // [R10] receive indication offset
  assign rx_dly_cycles = ts_cycles(timestamp_timing_config_reg[`TC_RX_MSB:`TC_RX_LSB]);

  sfd_delay u_tx_dly
  (
    .sys_clk      (sys_clk),
    .nrst         (nrst),
    .pulse_in     (tx_sfd_pulse),
    .delay_cycles (tx_dly_cycles),
    .pulse_out    (tx_sfd_dly)
  );

  sfd_delay u_rx_dly
  (
    .sys_clk      (sys_clk),
    .nrst         (nrst),
    .pulse_in     (rx_sfd_pulse),
    .delay_cycles (rx_dly_cycles),
    .pulse_out    (rx_sfd_dly)
  );

  // [R7] transmit pulse pin
  assign tx_pin   = pin_sel_t'(timestamp_pin_select_reg[`PS_TX_MSB:`PS_TX_LSB]);
  // [R8] receive pulse pin
  assign rx_pin   = pin_sel_t'(timestamp_pin_select_reg[`PS_RX_MSB:`PS_RX_LSB]);
  // [R11] transmit error source
  assign txer_pin = txer_sel_t'(timestamp_timing_config_reg[`TC_TXER_MSB:`TC_TXER_LSB]);

  // [R16] pin takeover; both pulses on one pin are ored
  // an error input wins over a pulse on the same pin, since it must float
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      led_zero_pin            <= 1'b0;
      crs_pin                 <= 1'b0;
      col_out                 <= 1'b0;
      col_oe                  <= 1'b0;
      interrupt_powerdown_out <= 1'b0;
      interrupt_powerdown_oe  <= 1'b0;
    end
    else
    begin
      if (tx_pin == PIN_LED || rx_pin == PIN_LED)
        led_zero_pin <= (tx_pin == PIN_LED && tx_sfd_dly) || (rx_pin == PIN_LED && rx_sfd_dly);
      else
        led_zero_pin <= led_zero_func;
      if (tx_pin == PIN_CRS || rx_pin == PIN_CRS)
        crs_pin <= (tx_pin == PIN_CRS && tx_sfd_dly) || (rx_pin == PIN_CRS && rx_sfd_dly);
      else
        crs_pin <= crs_func;
      if (txer_pin == TXER_COL)
      begin
        col_out <= 1'b0;
        col_oe  <= 1'b0;
      end
      else if (tx_pin == PIN_COL || rx_pin == PIN_COL)
      begin
        col_out <= (tx_pin == PIN_COL && tx_sfd_dly) || (rx_pin == PIN_COL && rx_sfd_dly);
        col_oe  <= 1'b1;
      end
      else
      begin
        col_out <= col_func_out;
        col_oe  <= col_func_oe;
      end
      if (txer_pin == TXER_INT)
      begin
        interrupt_powerdown_out <= 1'b0;
        interrupt_powerdown_oe  <= 1'b0;
      end
      else if (tx_pin == PIN_INT || rx_pin == PIN_INT)
      begin
        interrupt_powerdown_out <= (tx_pin == PIN_INT && tx_sfd_dly) || (rx_pin == PIN_INT && rx_sfd_dly);
        interrupt_powerdown_oe  <= 1'b1;
      end
      else
      begin
        interrupt_powerdown_out <= int_func_out;
        interrupt_powerdown_oe  <= int_func_oe;
      end
    end
  end

  // [R11] error input sampling
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      tx_error <= 1'b0;
    else
    begin
      case (txer_pin)
        TXER_INT: tx_error <= interrupt_powerdown_in;
        TXER_COL: tx_error <= col_in;
        default:  tx_error <= 1'b0;
      endcase
    end
  end

  // [R12] descrambler unlock timer
  assign descr_unlock_timer = timestamp_timing_config_reg[`TC_DSU_MSB:`TC_DSU_LSB];
  // [R13] forced 100 Mbps link
  assign force_100_link     = fiber_far_end_fault_force_reg[`FF_FORCE100_BIT];

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      far_end_fault_gen      <= 1'b0;
      far_end_fault_detected <= 1'b0;
    end
    else
    begin
      // [R14] generation gate
      far_end_fault_gen      <= far_end_fault_req && !fiber_far_end_fault_force_reg[`FF_GEN_DIS_BIT];
      // [R15] detection gate
      far_end_fault_detected <= far_end_fault_rx && !fiber_far_end_fault_force_reg[`FF_DET_DIS_BIT];
    end
  end

endmodule

// file: phy_cfg_defs.svh
`ifndef PHY_CFG_DEFS_SVH
`define PHY_CFG_DEFS_SVH

// register offsets
`define ADDR_COMPLIANCE   16'h0027
`define ADDR_PIN_SEL      16'h003E
`define ADDR_TIMING       16'h003F
`define ADDR_FAULT        16'h0040
`define ADDR_TX100_EXT    16'h0428

// reset values
`define RST_COMPLIANCE    16'h0000
`define RST_PIN_SEL       16'h0000
`define RST_TIMING        16'hB4FF
`define RST_FAULT         16'hC11D
`define RST_TX100_EXT     16'h0000

// writable bit masks, other bits read zero
`define MASK_PIN_SEL      16'h0077
`define MASK_TX100_EXT    16'h0030

// field positions
`define CT_TE_EN_BIT      4
`define CT_SEL_MSB        3
`define CT_SEL_LSB        0
`define EXT_EN_BIT        4
`define EXT_MSB_BIT       5
`define PS_TX_MSB         6
`define PS_TX_LSB         4
`define PS_RX_MSB         2
`define PS_RX_LSB         0
`define TC_TX_MSB         15
`define TC_TX_LSB         13
`define TC_RX_MSB         12
`define TC_RX_LSB         10
`define TC_TXER_MSB       9
`define TC_TXER_LSB       8
`define TC_DSU_MSB        7
`define TC_DSU_LSB        4
`define FF_FORCE100_BIT   13
`define FF_GEN_DIS_BIT    6
`define FF_DET_DIS_BIT    5

// highest valid 10BASE-Te pattern code
`define TE_SEL_MAX        4'hC

// timing
`define TS_STEP_NS        8
`define CLK_PERIOD_NS     10

`endif

// file: phy_cfg_pkg.sv
package phy_cfg_pkg;

  typedef enum logic [2:0]
  {
    PIN_LED  = 3'h3,
    PIN_CRS  = 3'h4,
    PIN_COL  = 3'h5,
    PIN_INT  = 3'h6,
    PIN_NONE = 3'h7
  } pin_sel_t;

  typedef enum logic [1:0]
  {
    TXER_NONE = 2'h0,
    TXER_INT  = 2'h2,
    TXER_COL  = 2'h3
  } txer_sel_t;

  typedef enum logic [2:0]
  {
    TXG_IDLE = 3'h1,
    TXG_ONE  = 3'h2,
    TXG_ZERO = 3'h4
  } txgen_state_t;

endpackage

// file: sfd_delay.sv
`timescale 1ns/1ps
module sfd_delay
  import phy_cfg_pkg::*;
#(
  parameter int CW    = 3,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          nrst,
  // pulse path
  input  wire logic          pulse_in,
  input  wire logic [CW-1:0] delay_cycles,
  output logic               pulse_out
);

  logic [DEPTH-1:0] shift_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      shift_reg <= '0;
    else
      shift_reg <= {shift_reg[DEPTH-2:0], pulse_in};
  end

  // zero delay still registers once
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      pulse_out <= 1'b0;
    else if (delay_cycles == '0)
      pulse_out <= pulse_in;
    else
      pulse_out <= shift_reg[delay_cycles - CW'(1)];
  end

endmodule

// file: tx_test_pattern_gen.sv
`timescale 1ns/1ps
module tx_test_pattern_gen
  import phy_cfg_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // control
  input  wire logic       enable,
  input  wire logic [4:0] zero_count,
  // pattern
  output logic            bit_out
);

  txgen_state_t state_reg;
  logic [4:0]   cnt_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state_reg <= TXG_IDLE;
      cnt_reg   <= 5'h00;
      bit_out   <= 1'b0;
    end
    else if (!enable || zero_count == 5'h00)
    begin
      state_reg <= TXG_IDLE;
      cnt_reg   <= 5'h00;
      bit_out   <= 1'b0;
    end
    else
    begin
      case (state_reg)
        TXG_IDLE, TXG_ZERO:
        begin
          if (state_reg == TXG_ZERO && cnt_reg != 5'h00)
          begin
            cnt_reg <= cnt_reg - 5'h01;
            bit_out <= 1'b0;
          end
          else
          begin
            state_reg <= TXG_ONE;
            bit_out   <= 1'b1;
          end
        end
        TXG_ONE:
        begin
          state_reg <= TXG_ZERO;
          cnt_reg   <= zero_count - 5'h01;
          bit_out   <= 1'b0;
        end
        default:
        begin
          state_reg <= TXG_IDLE;
          bit_out   <= 1'b0;
        end
      endcase
    end
  end

endmodule

// file: phy_cfg_checker.sv
`timescale 1ns/1ps
`include "phy_cfg_defs.svh"
module phy_cfg_checker
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // pins
  input wire logic        tx_sfd_pulse,
  input wire logic        crs_pin,
  input wire logic        col_in,
  input wire logic        interrupt_powerdown_in,
  input wire logic        interrupt_powerdown_oe,
  input wire logic        tx_error,
  // test and link
  input wire logic        te_test_active,
  input wire logic [3:0]  te_test_select,
  input wire logic        tx100_test_active,
  input wire logic [4:0]  tx100_zero_count,
  input wire logic [3:0]  descr_unlock_timer,
  input wire logic        force_100_link,
  input wire logic        far_end_fault_req,
  input wire logic        far_end_fault_gen,
  input wire logic        far_end_fault_rx,
  input wire logic        far_end_fault_detected
);
  logic [15:0] ct_reg, ps_reg, tc_reg, ff_reg;
  logic        ext_reg;

  // shadows of the written registers, masks ignored where no field is read
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      ct_reg  <= 16'h0000;
      ps_reg  <= 16'h0000;
      tc_reg  <= 16'hB4FF;
      ff_reg  <= 16'hC11D;
      ext_reg <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `ADDR_COMPLIANCE) ct_reg <= reg_wdata;
      if (reg_addr == `ADDR_PIN_SEL) ps_reg <= reg_wdata;
      if (reg_addr == `ADDR_TIMING) tc_reg <= reg_wdata;
      if (reg_addr == `ADDR_FAULT) ff_reg <= reg_wdata;
      if (reg_addr == `ADDR_TX100_EXT) ext_reg <= reg_wdata[4];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_tx_crs; tx_sfd_pulse && ps_reg[6:4] == 3'h4 && ps_reg[2:0] != 3'h4 && tc_reg[15:13] == 3'h5; endsequence
  sequence s_ext_rise; reg_wr && reg_addr == `ADDR_TX100_EXT && reg_wdata[4] && !ext_reg; endsequence

  property p_rdata_idle; reg_rdata != 16'h0000 |-> $past(reg_rd); endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_rd_timing; $past(reg_rd) && $past(reg_addr) == `ADDR_TIMING |-> reg_rdata == $past(tc_reg); endproperty
  a_rd_timing: assert property (p_rd_timing) else $error("timing readback wrong");
  property p_te; $past(nrst) |-> te_test_active == ($past(ct_reg[4]) && $past(ct_reg[3:0]) <= 4'hC)
    && te_test_select == $past(ct_reg[3:0]); endproperty
  a_te: assert property (p_te) else $error("10BASE-Te control wrong");
  property p_tx100; s_ext_rise |-> ##3 tx100_test_active
    && tx100_zero_count == {$past(reg_wdata[5], 3), $past(ct_reg[3:0], 3)}; endproperty
  a_tx100: assert property (p_tx100) else $error("100BASE-TX test start wrong");
  property p_sfd_crs; s_tx_crs |-> ##6 crs_pin; endproperty
  a_sfd_crs: assert property (p_sfd_crs) else $error("tx pulse late or missing on CRS");
  property p_txer; $past(nrst) |-> tx_error == (($past(tc_reg[9:8]) == 2'h2 && $past(interrupt_powerdown_in))
    || ($past(tc_reg[9:8]) == 2'h3 && $past(col_in))); endproperty
  a_txer: assert property (p_txer) else $error("tx error source wrong");
  property p_txer_oe; $past(nrst) && $past(tc_reg[9:8]) == 2'h2 |-> !interrupt_powerdown_oe; endproperty
  a_txer_oe: assert property (p_txer_oe) else $error("error input pin driven");
  property p_timer; descr_unlock_timer == tc_reg[7:4]; endproperty
  a_timer: assert property (p_timer) else $error("unlock timer wrong");
  property p_force; force_100_link == ff_reg[13]; endproperty
  a_force: assert property (p_force) else $error("force link wrong");
  property p_gen; $past(nrst) |-> far_end_fault_gen == ($past(far_end_fault_req) && !$past(ff_reg[6])); endproperty
  a_gen: assert property (p_gen) else $error("fault generation wrong");
  property p_det; $past(nrst) |-> far_end_fault_detected == ($past(far_end_fault_rx) && !$past(ff_reg[5])); endproperty
  a_det: assert property (p_det) else $error("fault detection wrong");
endmodule

bind phy_test_ptp_fef_config phy_cfg_checker chk_u
(
  .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_sfd_pulse, .crs_pin, .col_in,
  .interrupt_powerdown_in, .interrupt_powerdown_oe, .tx_error, .te_test_active, .te_test_select,
  .tx100_test_active, .tx100_zero_count, .descr_unlock_timer, .force_100_link, .far_end_fault_req,
  .far_end_fault_gen, .far_end_fault_rx, .far_end_fault_detected
);

// file: testbench.sv
`timescale 1ns/1ps
`include "phy_cfg_defs.svh"
module testbench;
  logic        sys_clk, nrst, reg_wr, reg_rd, tx_sfd_pulse, rx_sfd_pulse, led_zero_func, crs_func;
  logic        col_func_out, col_func_oe, int_func_out, int_func_oe, col_in, interrupt_powerdown_in;
  logic        far_end_fault_req, far_end_fault_rx, led_zero_pin, crs_pin, col_out, col_oe, tx_error;
  logic        interrupt_powerdown_out, interrupt_powerdown_oe, te_test_active, te_test_bit;
  logic        tx100_test_active, tx100_shift_clear, tx100_test_bit;
  logic        force_100_link, far_end_fault_gen, far_end_fault_detected;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0]  te_test_select, descr_unlock_timer;
  logic [4:0]  tx100_zero_count;
  int          failures, compares;

  phy_test_ptp_fef_config dut_u
  (
    .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_sfd_pulse, .rx_sfd_pulse,
    .led_zero_func, .crs_func, .col_func_out, .col_func_oe, .int_func_out, .int_func_oe, .led_zero_pin,
    .crs_pin, .col_in, .col_out, .col_oe, .interrupt_powerdown_in, .interrupt_powerdown_out,
    .interrupt_powerdown_oe, .tx_error, .te_test_active, .te_test_select, .te_test_bit, .tx100_test_active,
    .tx100_zero_count, .tx100_shift_clear, .tx100_test_bit, .descr_unlock_timer, .force_100_link,
    .far_end_fault_req, .far_end_fault_gen, .far_end_fault_rx, .far_end_fault_detected
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // data sampled mid-cycle: it stands for that one cycle only
  task automatic rdchk(input string n, input logic [15:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(n, e, reg_rdata);
  endtask

  function automatic logic pin_v(input int p);
    case (p)
      3: return led_zero_pin;
      4: return crs_pin;
      5: return col_out & col_oe;
      default: return interrupt_powerdown_out & interrupt_powerdown_oe;
    endcase
  endfunction

  // e of 12 means the pulse must not show at all
  task automatic lat(input bit tx, input int p, input int e);
    int n;
    @(posedge sys_clk);
    tx_sfd_pulse <= tx;
    rx_sfd_pulse <= !tx;
    @(posedge sys_clk);
    tx_sfd_pulse <= 1'b0;
    rx_sfd_pulse <= 1'b0;
    #1;
    n = 1;
    while (pin_v(p) !== 1'b1 && n < 12)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("sfd latency", 16'(e), 16'(n));
    if (n == 12 && e != 12)
      results;
    settle(10);
  endtask

  task automatic t_regs;
    rdchk("compliance", `ADDR_COMPLIANCE, 16'h0000);
    rdchk("pin sel", `ADDR_PIN_SEL, 16'h0000);
    rdchk("timing", `ADDR_TIMING, 16'hB4FF);
    rdchk("fault", `ADDR_FAULT, 16'hC11D);
    rdchk("ext", `ADDR_TX100_EXT, 16'h0000);
    chk("timer", 16'h000F, descr_unlock_timer);
    wr(`ADDR_PIN_SEL, 16'hFFFF);
    rdchk("pin sel ro", `ADDR_PIN_SEL, 16'h0077);
    wr(`ADDR_TX100_EXT, 16'hFFEF);
    rdchk("ext ro", `ADDR_TX100_EXT, 16'h0020);
    wr(16'h0041, 16'h1234);
    rdchk("unmapped", 16'h0041, 16'h0000);
    wr(`ADDR_TIMING, 16'hB45F);
    settle(0);
    chk("timer", 16'h0005, descr_unlock_timer);
    wr(`ADDR_TIMING, 16'hB4FF);
  endtask

  task automatic t_te;
    for (int c = 0; c < 16; c++)
    begin
      wr(`ADDR_COMPLIANCE, 16'h0010 | 16'(c));
      settle(3);
      chk("te active", 16'(c <= 12), te_test_active);
      chk("te select", 16'(c), te_test_select);
      if (c == 3 || c == 4)
        chk("te bit", 16'(c == 3), te_test_bit);
    end
    wr(`ADDR_COMPLIANCE, 16'h0003);
    settle(2);
    chk("te off", 16'h0000, te_test_active);
  endtask

  task automatic t_tx100;
    int k;
    wr(`ADDR_TX100_EXT, 16'h0010);
    settle(2);
    chk("100 active", 16'h0001, tx100_test_active);
    chk("100 zeros", 16'h0003, tx100_zero_count);
    k = 0;
    repeat (20) @(negedge sys_clk) if (tx100_test_bit === 1'b1) k++;
    chk("100 ones", 16'h0005, 16'(k));
    wr(`ADDR_COMPLIANCE, 16'h0005);
    settle(2);
    chk("100 held", 16'h0003, tx100_zero_count);
    wr(`ADDR_TX100_EXT, 16'h0000);
    wr(`ADDR_TX100_EXT, 16'h0030);
    settle(2);
    chk("100 reload", 16'h0015, tx100_zero_count);
    // value zero only clears the shift register
    wr(`ADDR_COMPLIANCE, 16'h0000);
    wr(`ADDR_TX100_EXT, 16'h0000);
    wr(`ADDR_TX100_EXT, 16'h0010);
    settle(3);
    chk("100 clear", 16'h0001, tx100_shift_clear);
    chk("100 bit", 16'h0000, tx100_test_bit);
    wr(`ADDR_TX100_EXT, 16'h0000);
    settle(3);
    chk("100 off", 16'h0000, tx100_test_active);
  endtask

  task automatic t_sfd;
    @(posedge sys_clk);
    led_zero_func <= 1'b1;
    settle(1);
    chk("led normal", 16'h0001, led_zero_pin);
    wr(`ADDR_PIN_SEL, 16'h0037);
    settle(1);
    chk("led taken", 16'h0000, led_zero_pin);
    @(posedge sys_clk);
    led_zero_func <= 1'b0;
    for (int p = 3; p < 7; p++)
    begin
      wr(`ADDR_PIN_SEL, 16'(p << 4) | 16'h0007);
      lat(1, p, 6);
      wr(`ADDR_PIN_SEL, 16'h0070 | 16'(p));
      lat(0, p, 6);
    end
    wr(`ADDR_PIN_SEL, 16'h0077);
    lat(1, 3, 12);
    // rounded up to whole 10 ns cycles
    for (int s = 0; s < 8; s++)
    begin
      wr(`ADDR_TIMING, 16'h00FF | 16'(s << 13) | 16'(s << 10));
      wr(`ADDR_PIN_SEL, 16'h0047);
      lat(1, 4, (s * 8 + 9) / 10 + 2);
      wr(`ADDR_PIN_SEL, 16'h0074);
      lat(0, 4, (s * 8 + 9) / 10 + 2);
    end
  endtask

  task automatic t_txer;
    @(posedge sys_clk);
    int_func_oe <= 1'b1;
    int_func_out <= 1'b1;
    for (int s = 0; s < 4; s++)
      for (int v = 0; v < 2; v++)
      begin
        @(posedge sys_clk);
        interrupt_powerdown_in <= v[0];
        col_in <= !v[0];
        wr(`ADDR_TIMING, 16'hB4FF & 16'hFCFF | 16'(s << 8));
        settle(2);
        chk("tx error", 16'((s == 2 && v == 1) || (s == 3 && v == 0)), tx_error);
        chk("int oe", 16'(s != 2), interrupt_powerdown_oe);
      end
    wr(`ADDR_TIMING, 16'hB4FF);
    int_func_oe <= 1'b0;
  endtask

  task automatic t_fault;
    @(posedge sys_clk);
    far_end_fault_req <= 1'b1;
    far_end_fault_rx <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      wr(`ADDR_FAULT, 16'hC11D | (m[0] ? 16'h2040 : 16'h0000) | (m[1] ? 16'h0020 : 16'h0000));
      settle(2);
      chk("fault gen", 16'(!m[0]), far_end_fault_gen);
      chk("fault det", 16'(!m[1]), far_end_fault_detected);
      chk("force 100", 16'(m[0]), force_100_link);
    end
  endtask

  initial
  begin
    {nrst, reg_wr, reg_rd, tx_sfd_pulse, rx_sfd_pulse, led_zero_func, crs_func, col_func_out} = 8'h00;
    {col_func_oe, int_func_out, int_func_oe, col_in, interrupt_powerdown_in} = 5'h00;
    {far_end_fault_req, far_end_fault_rx} = 2'h0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    failures = 0;
    compares = 0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs;
    t_te;
    t_tx100;
    t_sfd;
    t_txer;
    t_fault;
    results;
  end
endmodule
